// ---- inc/ccs_pkg.sv ----
// constants and types for the common command and status unit
package ccs_pkg;

   // ----------------------------------------------------------------
   // characters
   // ----------------------------------------------------------------
   localparam logic [7:0] CH_LF    = 8'h0a;
   localparam logic [7:0] CH_SP    = 8'h20;
   localparam logic [7:0] CH_QUOTE = 8'h22;
   localparam logic [7:0] CH_DOT   = 8'h2e;
   localparam logic [7:0] CH_QRY   = 8'h3f;
   localparam logic [7:0] CH_ZERO  = 8'h30;
   localparam logic [7:0] CH_NINE  = 8'h39;
   localparam logic [7:0] CH_LC_A  = 8'h61;
   localparam logic [7:0] CH_LC_Z  = 8'h7a;
   localparam logic [7:0] CASE_BIT = 8'h20;

   // ----------------------------------------------------------------
   // keywords, four characters each; MAX and MIN arguments three characters each
   // ----------------------------------------------------------------
   localparam logic [31:0] KW_IDN = "*IDN";
   localparam logic [31:0] KW_OPC = "*OPC";
   localparam logic [31:0] KW_OPT = "*OPT";
   localparam logic [31:0] KW_RST = "*RST";
   localparam logic [31:0] KW_SRE = "*SRE";
   localparam logic [31:0] KW_CLS = "*CLS";
   localparam logic [31:0] KW_STB = "*STB";
   localparam logic [2:0]  KW_LEN = 3'd4;
   localparam logic [23:0] ARG_MAX = "MAX";
   localparam logic [23:0] ARG_MIN = "MIN";

   // ----------------------------------------------------------------
   // answers; identity text and option code are arbitrary values
   // ----------------------------------------------------------------
   localparam int          RSP_BYTES = 24;
   localparam logic [175:0] IDN_STR  = "MAKERCO,MOD100,A.01.00";
   localparam logic [4:0]  IDN_LEN   = 5'd23;
   localparam logic [23:0] OPT_CODE  = "FCK";
   localparam logic [4:0]  OPT_LEN   = 5'd6;
   localparam logic [4:0]  NOOPT_LEN = 5'd3;

   // ----------------------------------------------------------------
   // mask and status byte layout, reset values
   // ----------------------------------------------------------------
   localparam int         SUM_BIT   = 6;
   localparam int         MAV_BIT   = 4;
   localparam int         RSV_BIT   = 1;
   localparam logic [7:0] SRE_WMASK = 8'hbf;
   localparam logic [7:0] SRE_RST   = 8'h00;
   localparam logic [8:0] NUM_SAT   = 9'h100;
   localparam logic [7:0] NUM_MAX   = 8'hff;
   localparam logic [1:0] INIT_CYC  = 2'd3;

   typedef enum logic [1:0] {PH_INIT, PH_RECV, PH_SEND} ccs_phase_t;

endpackage

// ---- verilog/ccs_unit.sv ----
// common command interpreter with service request logic
// Notes on behaviour
// - identification query answers maker, product and software version, comma separated
// - operation complete command and query accepted; query answers 1, flag presets 0
// - option query answers the quoted option code when the fast clock is fitted
// - option query answers an empty quoted string on the standard clock
// - reset command clears the operation complete flag and pulses device reset; the enable mask is kept
// - enable mask written as decimal 0 to 255; device stores those bits
// - any value written to mask bit 6 is ignored
// - service requested when an enabled status bit rises
// - service requested when a mask bit rises over a set status bit
// - mask query answers the decimal sum of set bits
// - mask preset depends on the power-on status clear flag
// - status bit 6 is summary on query, request flag on serial poll
// - clear status clears all event registers
`timescale 1ns/1ps
module ccs_unit
   import ccs_pkg::*;
#(
   parameter logic [7:0] P_SRE_KEEP = 8'h00
) (
   input  wire logic       i_clk_sys,
   input  wire logic       i_rst_b,
   input  wire logic       i_rx_valid,
   input  wire logic [7:0] i_rx_data,
   output logic            o_rx_ready,
   output logic            o_tx_valid,
   output logic [7:0]      o_tx_data,
   input  wire logic       i_tx_ready,
   input  wire logic [7:0] i_stb_sum,
   input  wire logic       i_spoll,
   input  wire logic       i_opt_fast_clk,
   input  wire logic       i_pwr_on_clr,
   output logic            o_srq,
   output logic [7:0]      o_poll_byte,
   output logic            o_poll_valid,
   output logic [7:0]      o_sre_mask,
   output logic            o_dev_rst,
   output logic            o_clr_status,
   output logic            o_opc_event,
   output logic            o_cmd_err
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      ccs_phase_t               phase;
      logic [1:0]               init_cnt;
      logic                     opt_s1;
      logic                     opt_s2;
      logic                     psc_s1;
      logic                     psc_s2;
      logic [31:0]              hdr;
      logic [2:0]               hdr_n;
      logic                     qry;
      logic                     in_arg;
      logic                     in_frac;
      logic                     bad;
      logic [8:0]               num;
      logic [23:0]              arg_let;
      logic [7:0]               mask;
      logic [7:0]               mask_prev;
      logic [7:0]               stb_prev;
      logic                     request_service_flag;
      logic                     opc;
      logic [8*RSP_BYTES-1:0]   rsp;
      logic [4:0]               rsp_n;
      logic                     rx_ready;
      logic                     tx_valid;
      logic                     dev_rst;
      logic                     cls;
      logic                     opc_ev;
      logic                     cmd_err;
      logic [7:0]               poll_byte;
      logic                     poll_valid;
   } ccs_state_t;

   ccs_state_t s_q;
   ccs_state_t s_d;

   logic [7:0]  stb_now;
   logic        master_summary_flag;
   logic [7:0]  srq_rise;
   logic [7:0]  ch;
   logic [12:0] num_ext;
   logic [7:0]  arg_val;
   logic        eol;
   logic        is_kw;

   // decimal answer: digits then line feed, leading zeros dropped
   function automatic logic [36:0] dec_rsp(input logic [7:0] v);
      logic [7:0]  d2;
      logic [7:0]  d1;
      logic [7:0]  d0;
      logic [31:0] w;
      logic [4:0]  n;
      d2 = CH_ZERO + v / 8'd100;
      d1 = CH_ZERO + (v / 8'd10) % 8'd10;
      d0 = CH_ZERO + v % 8'd10;
      w  = {d2, d1, d0, CH_LF};
      n  = 5'd4;
      if (v < 8'd100) begin
         w = {w[23:0], 8'h00};
         n = 5'd3;
      end
      if (v < 8'd10) begin
         w = {w[23:0], 8'h00};
         n = 5'd2;
      end
      return {n, w};
   endfunction

   // ----------------------------------------------------------------
   // status byte and service request
   // ----------------------------------------------------------------
   always_comb begin
      stb_now          = i_stb_sum;
      stb_now[MAV_BIT] = (s_q.phase == PH_SEND);
      stb_now[RSV_BIT] = 1'b0;
      stb_now[SUM_BIT] = 1'b0;
      master_summary_flag = |(stb_now & s_q.mask);
      srq_rise = stb_now & ~s_q.stb_prev & s_q.mask;
      srq_rise = srq_rise | (s_q.mask & ~s_q.mask_prev & stb_now);
   end

   // ----------------------------------------------------------------
   // character handling
   // ----------------------------------------------------------------
   always_comb begin
      ch = i_rx_data;
      if (i_rx_data >= CH_LC_A && i_rx_data <= CH_LC_Z) begin
         ch = i_rx_data & ~CASE_BIT;
      end
      eol     = i_rx_valid && s_q.rx_ready && ch == CH_LF;
      is_kw   = s_q.hdr_n == KW_LEN && !s_q.bad;
      num_ext = 13'(s_q.num) * 13'd10 + 13'(ch - CH_ZERO);
      if (s_q.arg_let == ARG_MAX || s_q.num[8]) begin
         arg_val = NUM_MAX;
      end else if (s_q.arg_let == ARG_MIN) begin
         arg_val = 8'h00;
      end else begin
         arg_val = s_q.num[7:0];
      end
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [36:0] dr;
      dr            = 37'h0;
      s_d           = s_q;
      s_d.opt_s1    = i_opt_fast_clk;
      s_d.opt_s2    = s_q.opt_s1;
      s_d.psc_s1    = i_pwr_on_clr;
      s_d.psc_s2    = s_q.psc_s1;
      s_d.stb_prev  = stb_now;
      s_d.mask_prev = s_q.mask;
      s_d.dev_rst   = 1'b0;
      s_d.cls       = 1'b0;
      s_d.opc_ev    = 1'b0;
      s_d.cmd_err   = 1'b0;
      s_d.poll_valid = 1'b0;
      // request held until polled, a new rise wins
      s_d.request_service_flag = (|srq_rise) || (s_q.request_service_flag && !i_spoll);
      if (i_spoll) begin
         // poll shows request flag in bit 6
         s_d.poll_byte          = stb_now;
         s_d.poll_byte[SUM_BIT] = s_q.request_service_flag;
         s_d.poll_valid         = 1'b1;
      end
      case (s_q.phase)
         PH_INIT: begin
            s_d.init_cnt = s_q.init_cnt + 2'd1;
            if (s_q.init_cnt == INIT_CYC) begin
               // preset chosen by power-on clear flag
               s_d.mask     = s_q.psc_s2 ? SRE_RST : P_SRE_KEEP & SRE_WMASK;
               s_d.rx_ready = 1'b1;
               s_d.phase    = PH_RECV;
            end
         end
         PH_RECV: begin
            if (i_rx_valid && ch != CH_LF) begin
               if (!s_q.in_arg) begin
                  if (ch == CH_SP) begin
                     s_d.in_arg = 1'b1;
                  end else if (ch == CH_QRY) begin
                     s_d.qry = 1'b1;
                  end else begin
                     s_d.bad   = s_q.bad | s_q.qry;
                     s_d.hdr   = {s_q.hdr[23:0], ch};
                     s_d.hdr_n = (s_q.hdr_n == 3'd7) ? 3'd7 : s_q.hdr_n + 3'd1;
                  end
               end else if (ch >= CH_ZERO && ch <= CH_NINE) begin
                  if (!s_q.in_frac) begin
                     s_d.num = (num_ext > 13'(NUM_MAX)) ? NUM_SAT : num_ext[8:0];
                  end
               end else if (ch == CH_DOT) begin
                  s_d.in_frac = 1'b1;
               end else if (ch != CH_SP) begin
                  s_d.arg_let = {s_q.arg_let[15:0], ch};
               end
            end
            if (eol) begin
               s_d.hdr     = 32'h0;
               s_d.hdr_n   = 3'd0;
               s_d.qry     = 1'b0;
               s_d.in_arg  = 1'b0;
               s_d.in_frac = 1'b0;
               s_d.bad     = 1'b0;
               s_d.num     = 9'h0;
               s_d.arg_let = 24'h0;
               s_d.rsp     = '0;
               s_d.rsp_n   = 5'd0;
               if (is_kw && s_q.qry && s_q.hdr == KW_IDN) begin
                  s_d.rsp   = {IDN_STR, CH_LF, 8'h00};
                  s_d.rsp_n = IDN_LEN;
               end else if (is_kw && s_q.qry && s_q.hdr == KW_OPT) begin
                  if (s_q.opt_s2) begin
                     s_d.rsp[191:144] = {CH_QUOTE, OPT_CODE, CH_QUOTE, CH_LF};
                     s_d.rsp_n        = OPT_LEN;
                  end else begin
                     s_d.rsp[191:168] = {CH_QUOTE, CH_QUOTE, CH_LF};
                     s_d.rsp_n        = NOOPT_LEN;
                  end
               end else if (is_kw && s_q.hdr == KW_OPC) begin
                  if (s_q.qry) begin
                     dr = dec_rsp(8'h01);
                  end else begin
                     s_d.opc    = 1'b1;
                     s_d.opc_ev = 1'b1;
                  end
               end else if (is_kw && !s_q.qry && s_q.hdr == KW_RST) begin
                  s_d.opc     = 1'b0;
                  s_d.dev_rst = 1'b1;
               end else if (is_kw && s_q.hdr == KW_SRE) begin
                  if (s_q.qry) begin
                     dr = dec_rsp(s_q.mask);
                  end else if (s_q.in_arg) begin
                     s_d.mask = arg_val & SRE_WMASK;
                  end else begin
                     s_d.cmd_err = 1'b1;
                  end
               end else if (is_kw && s_q.qry && s_q.hdr == KW_STB) begin
                  // query shows summary in bit 6
                  dr = dec_rsp(stb_now | (8'(master_summary_flag) << SUM_BIT));
               end else if (is_kw && !s_q.qry && s_q.hdr == KW_CLS) begin
                  s_d.cls = 1'b1;
                  s_d.opc = 1'b0;
               end else begin
                  s_d.cmd_err = 1'b1;
               end
               if (dr[36:32] != 5'd0) begin
                  s_d.rsp[191:160] = dr[31:0];
                  s_d.rsp_n        = dr[36:32];
               end
               if (s_d.rsp_n != 5'd0) begin
                  s_d.rx_ready = 1'b0;
                  s_d.tx_valid = 1'b1;
                  s_d.phase    = PH_SEND;
               end
            end
         end
         PH_SEND: begin
            if (i_tx_ready) begin
               s_d.rsp   = {s_q.rsp[8*RSP_BYTES-9:0], 8'h00};
               s_d.rsp_n = s_q.rsp_n - 5'd1;
               if (s_q.rsp_n == 5'd1) begin
                  s_d.tx_valid = 1'b0;
                  s_d.rx_ready = 1'b1;
                  s_d.phase    = PH_RECV;
               end
            end
         end
         default: begin
            s_d.phase = PH_INIT;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         s_q       <= '0;
         s_q.phase <= PH_INIT;
         s_q.mask  <= SRE_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_rx_ready   = s_q.rx_ready;
   assign o_tx_valid   = s_q.tx_valid;
   assign o_tx_data    = s_q.rsp[8*RSP_BYTES-1 -: 8];
   assign o_srq        = s_q.request_service_flag;
   assign o_poll_byte  = s_q.poll_byte;
   assign o_poll_valid = s_q.poll_valid;
   assign o_sre_mask   = s_q.mask;
   assign o_dev_rst    = s_q.dev_rst;
   assign o_clr_status = s_q.cls;
   assign o_opc_event  = s_q.opc_ev;
   assign o_cmd_err    = s_q.cmd_err;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rst_b);

   sequence s_eol_kw(logic [31:0] kw, logic q);
      eol && is_kw && s_q.hdr == kw && s_q.qry == q;
   endsequence

   a_srq_stb_rise: assert property (
      |(stb_now & ~s_q.stb_prev & s_q.mask) |=> o_srq)
      else $error("no service request on enabled status rise");
   a_srq_mask_rise: assert property (
      |(s_q.mask & ~s_q.mask_prev & stb_now) |=> o_srq)
      else $error("no service request on mask rise");
   a_mask_bit6: assert property (
      s_eol_kw(KW_SRE, 1'b0) ##0 s_q.in_arg |=> !o_sre_mask[SUM_BIT])
      else $error("mask bit 6 was stored");
   a_sre_store: assert property (
      s_eol_kw(KW_SRE, 1'b0) ##0 s_q.in_arg
      |=> o_sre_mask == ($past(arg_val) & SRE_WMASK))
      else $error("mask value not stored");
   a_poll_rqs: assert property (
      i_spoll |=> o_poll_valid && o_poll_byte[SUM_BIT] == $past(s_q.request_service_flag))
      else $error("poll byte bit 6 is not the request flag");
   a_rst_pulse: assert property (
      s_eol_kw(KW_RST, 1'b0) |=> o_dev_rst ##1 !o_dev_rst)
      else $error("reset command pulse wrong");
   a_cls_pulse: assert property (
      s_eol_kw(KW_CLS, 1'b0) |=> o_clr_status)
      else $error("clear status not issued");
   a_opc_reply: assert property (
      s_eol_kw(KW_OPC, 1'b1)
      |=> o_tx_valid && o_tx_data == (CH_ZERO + 8'h01))
      else $error("operation complete query did not answer 1");
   a_opt_empty: assert property (
      s_eol_kw(KW_OPT, 1'b1) ##0 !s_q.opt_s2
      |=> o_tx_data == CH_QUOTE && o_tx_valid)
      else $error("empty option answer wrong");
   a_idn_first: assert property (
      s_eol_kw(KW_IDN, 1'b1) |=> o_tx_valid && o_tx_data == IDN_STR[175:168])
      else $error("identity answer does not start with maker");

endmodule

// ---- tb/ccs_host.sv ----
// host controller model: sends command lines, takes answer lines
`timescale 1ns/1ps
module ccs_host
   import ccs_pkg::*;
(
   input  wire logic       i_clk_sys,
   input  wire logic       i_rx_ready,
   input  wire logic       i_tx_valid,
   input  wire logic [7:0] i_tx_data,
   output logic            o_rx_valid,
   output logic [7:0]      o_rx_data,
   output logic            o_tx_ready
);
   initial begin
      o_rx_valid = 1'b0;
      o_rx_data  = 8'h00;
      o_tx_ready = 1'b0;
   end

   // ----------------------------------------------------------------
   // command side
   // ----------------------------------------------------------------
   // mask values go out as decimal text
   // no settle wait: nothing here measures
   task send(input string s);
      for (int i = 0; i <= s.len(); i++) begin
         o_rx_data  = (i == s.len()) ? CH_LF : 8'(s[i]);
         o_rx_valid = 1'b1;
         do @(posedge i_clk_sys); while (i_rx_ready !== 1'b1);
         #1;
      end
      o_rx_valid = 1'b0;
      // idle data inverted so a stale byte never looks valid
      o_rx_data  = ~o_rx_data;
   endtask

   // ----------------------------------------------------------------
   // answer side; stall holds ready low between bytes
   // ----------------------------------------------------------------
   task recv(output string r, input int stall);
      logic [7:0] b;
      r = "";
      o_tx_ready = 1'b1;
      forever begin
         do @(posedge i_clk_sys); while (i_tx_valid !== 1'b1);
         b = i_tx_data;
         #1;
         if (b == CH_LF) begin
            o_tx_ready = 1'b0;
            break;
         end
         r = {r, string'(b)};
         if (stall > 0) begin
            o_tx_ready = 1'b0;
            repeat (stall) @(posedge i_clk_sys);
            #1 o_tx_ready = 1'b1;
         end
      end
   endtask
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench for the common command unit
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin \
   miscompares++; $display("[ERR] %s exp %0h got %0h", n, e, a); end end
module tb_top
   import ccs_pkg::*;
;
   logic       clk = 1'b0;
   logic       rst_b = 1'b0;
   logic       rx_valid, rx_ready, tx_valid, tx_ready, spoll, opt_fast;
   logic       pwr_clr, srq, poll_valid, dev_rst, clr_st, opc_ev, cmd_err;
   logic [7:0] rx_data, tx_data, stb, poll_byte, sre_mask;
   int         miscompares = 0;
   int         n_tests = 0;
   string      r;

   always #12.5 clk = ~clk;

   ccs_unit #(.P_SRE_KEEP(8'h24)) u_ccs_unit (
      .i_clk_sys(clk), .i_rst_b(rst_b), .i_rx_valid(rx_valid),
      .i_rx_data(rx_data), .o_rx_ready(rx_ready), .o_tx_valid(tx_valid),
      .o_tx_data(tx_data), .i_tx_ready(tx_ready), .i_stb_sum(stb),
      .i_spoll(spoll), .i_opt_fast_clk(opt_fast), .i_pwr_on_clr(pwr_clr),
      .o_srq(srq), .o_poll_byte(poll_byte), .o_poll_valid(poll_valid),
      .o_sre_mask(sre_mask), .o_dev_rst(dev_rst), .o_clr_status(clr_st),
      .o_opc_event(opc_ev), .o_cmd_err(cmd_err));

   ccs_host u_ccs_host (
      .i_clk_sys(clk), .i_rx_ready(rx_ready), .i_tx_valid(tx_valid),
      .i_tx_data(tx_data), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
      .o_tx_ready(tx_ready));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task complete_run;
      $display("compares %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task tick;
      @(posedge clk);
      #1;
   endtask

   task do_reset(input logic clr, input logic [7:0] e);
      int n;
      pwr_clr = clr;
      rst_b = 1'b0;
      repeat (8) tick;
      rst_b = 1'b1;
      n = 0;
      while (rx_ready !== 1'b1 && n < 20) begin
         tick;
         n++;
      end
      `CHK("sre preset", e, sre_mask)
   endtask

   task query(input string c, input int stall, input string e, string nm);
      u_ccs_host.send(c);
      u_ccs_host.recv(r, stall);
      `CHK(nm, 1'b1, r == e)
   endtask

   // pulses checked as {dev_rst, clr_status, opc_event, cmd_err}
   task cmd(input string c, input logic [3:0] e);
      logic [3:0] p;
      u_ccs_host.send(c);
      p = {dev_rst, clr_st, opc_ev, cmd_err};
      `CHK(c, e, p)
      tick;
      p = {dev_rst, clr_st, opc_ev, cmd_err};
      `CHK(c, 4'h0, p)
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task sre_tests;
      string      a[6];
      logic [7:0] e[6];
      a = '{"97", "255", "MAX", "min", "300", "40.7"};
      e = '{8'h21, 8'hbf, 8'hbf, 8'h00, 8'hbf, 8'h28};
      for (int i = 0; i < 6; i++) begin
         cmd({"*sre ", a[i]}, 4'h0); // mask write
         `CHK("mask", e[i], sre_mask) // bit six dropped
         query("*SRE?", 0, $sformatf("%0d", e[i]), "mask q"); // sum
      end
   endtask

   task srq_tests;
      // earlier answers may have left a request pending
      spoll = 1'b1;
      tick;
      spoll = 1'b0;
      tick;
      `CHK("srq idle", 1'b0, srq) // poll clears
      cmd("*SRE 1", 4'h0);
      stb = 8'h01;
      tick;
      `CHK("srq rise", 1'b1, srq) // enabled bit rises
      spoll = 1'b1;
      tick;
      spoll = 1'b0;
      `CHK("poll valid", 1'b1, poll_valid) // poll answers
      `CHK("poll byte", 8'h41, poll_byte) // request flag
      `CHK("srq clear", 1'b0, srq) // poll clears
      stb = 8'h05;
      tick;
      tick;
      `CHK("srq masked", 1'b0, srq) // masked bit quiet
      cmd("*SRE 5", 4'h0);
      `CHK("srq mask rise", 1'b1, srq) // mask rises
      query("*STB?", 0, "69", "stb q"); // summary bit
      stb = 8'h00;
   endtask

   initial begin
      stb = 8'h00;
      spoll = 1'b0;
      opt_fast = 1'b0;
      pwr_clr = 1'b0;
      do_reset(1'b0, 8'h24); // kept preset
      query("*Idn?", 2, string'(IDN_STR), "idn"); // identity
      query("*OPT?", 0, "\"\"", "opt none"); // empty option
      opt_fast = 1'b1;
      repeat (4) tick;
      query("*opt?", 1, {"\"", string'(OPT_CODE), "\""}, "opt");
      query("*OPC?", 0, "1", "opc q"); // completion query
      cmd("*opc", 4'h2); // completion command
      cmd("*Rst", 4'h8); // device reset
      `CHK("mask kept", 8'h24, sre_mask) // mask untouched
      cmd("*CLS", 4'h4); // clear status
      cmd("*XYZ", 4'h1);
      cmd("*SRE", 4'h1);
      cmd("*OPC?X", 4'h1);
      sre_tests;
      srq_tests;
      do_reset(1'b1, 8'h00); // cleared preset
      complete_run;
   end

   // run needs well under 5000 cycles
   initial begin
      repeat (5000) @(posedge clk);
      miscompares++;
      complete_run;
   end
endmodule
